// ### ddr3_mode_switch_control.sv
// Command decoder for pattern readout, idle commands and DLL-off mode.
// Summary of operation
// RULE1 - MR3 write with A2 set enables pattern
// RULE2 - Controller precharges all banks before enabling
// RULE3 - Reads return pattern data while enabled
// RULE4 - Controller issues only reads until disabled
// RULE5 - No power-down or refresh while enabled
// RULE6 - Reset still clears the pattern mode
// RULE7 - NOP changes nothing in progress
// RULE8 - Deselect ignores all other command inputs
// RULE9 - MR1 A0 selects DLL-off until cleared
// RULE10 - DLL-off supports read and write latency six
// RULE11 - DLL-off read strobe starts one cycle early
// RULE12 - Controller follows DLL-off switch sequence
// RULE13 - CKE high, ODT low after exit for tMOD
// RULE14 - Controller re-enables DLL then resets it
// RULE15 - Controller waits tDLLK before locked-DLL commands
// RULE16 - Clock changes only in refresh or power-down
// RULE17 - Clock ignored after tCKSRE in self refresh
// RULE18 - Power-down change waits tCKSRE, CKE ODT low
// RULE19 - Stable clock before exit, then DLL reset
// RULE20 - ODT low, CKE high during DLL relock
// RULE21 - Termination off when nominal termination disabled
// RULE22 - Optional long calibration needs tZQoper wait
// RULE23 - MR3 write needs BA1 BA0 high, BA2 low
// RULE24 - Pattern select ignored when pattern mode off
// RULE25 - Controller counts waits, sends only idle commands
`timescale 1ns/1ps
module ddr3_mode_switch_control (
    input  wire logic                mclk_in,
    input  wire logic                rstn_in,
    input  wire logic                cke_in,
    input  wire ddr3_msc_pkg::cmd_s  cmd_in,
    input  wire logic [2:0]          ba_in,
    input  wire logic [15:0]         addr_in,
    input  wire logic                odt_in,
    output logic                     cal_mode_out,
    output logic [1:0]               cal_sel_out,
    output logic                     dll_off_out,
    output logic                     dll_locked_out,
    output logic                     dqs_start_out,
    output logic                     rd_cal_out,
    output logic                     term_on_out,
    output logic                     clk_free_out,
    output logic [1:0]               pstate_out
);
    // ****************************************
    // Decoding helpers.
    // ****************************************
    // Matches the four command strobes against a pattern.
    function automatic logic is_cmd(input ddr3_msc_pkg::cmd_s c,
                                    input logic [3:0] pat);
        is_cmd = ({c.cs_n, c.ras_n, c.cas_n, c.we_n} == pat);
    endfunction

    // Read latency from additive latency and DLL state.
    function automatic logic [4:0] rd_lat(input logic [1:0] al,
                                          input logic dll_off);
        logic [4:0] lat;
        lat = ddr3_msc_pkg::LAT_CL;
        // Additive latency: code 1 adds CL-1, code 2 adds CL-2, the reserved code adds none.
        if (al == 2'h1) begin
            lat = 5'(lat + ddr3_msc_pkg::LAT_CL - 5'h01);
        end else if (al == 2'h2) begin
            lat = 5'(lat + ddr3_msc_pkg::LAT_CL - 5'h02);
        end
        // The strobe reference edge moves one cycle earlier.
        if (dll_off) begin
            lat = 5'(lat - 5'h01); // RULE11
        end
        rd_lat = lat;
    endfunction

    // ****************************************
    // State registers and decoded strobes.
    // ****************************************
    ddr3_msc_pkg::st_s st;      // Registered state.
    ddr3_msc_pkg::st_s next_st; // Next state.
    logic cmd_ok;  // Command slot sampled with the clock running.
    logic mrs_cmd; // Mode register set.
    logic rd_cmd;  // Read with or without auto-precharge.
    logic ref_cmd; // Refresh, enters self refresh with CKE low.
    logic nop_cmd; // No-operation.
    logic [4:0] lat; // Current read latency.

    // Commands count only while CKE stays high and the chip is active.
    always_comb begin
        cmd_ok  = cke_in && st.prev_cke
                  && (st.pstate == ddr3_msc_pkg::PS_ACTIVE);
        // Deselect never matches any pattern below.
        mrs_cmd = is_cmd(cmd_in, 4'h0);   // RULE8
        rd_cmd  = is_cmd(cmd_in, 4'h5);
        ref_cmd = is_cmd(cmd_in, 4'h1);
        nop_cmd = is_cmd(cmd_in, 4'h7);   // RULE7
        lat     = rd_lat(st.al_sel, st.dll_off);
    end

    // ****************************************
    // Next state logic.
    // ****************************************
    // Computes all state updates from the command slot, CKE, ODT and the running timers.
    always_comb begin
        next_st = st;
        next_st.prev_cke = cke_in;
        // Lock timer runs down to the locked state. It comes before the mode
        // register writes so that a DLL reset restarts a running count and
        // turning the DLL off stops it; a lock must never show in DLL-off mode.
        if (st.dllk_cnt != 10'h000) begin
            next_st.dllk_cnt = 10'(st.dllk_cnt - 10'h001);
            if (st.dllk_cnt == 10'h001) begin
                next_st.dll_locked = 1'b1;
            end
        end
        // Mode register writes; NOP and deselect fall through untouched.
        if (cmd_ok && mrs_cmd) begin
            case (ba_in)
                ddr3_msc_pkg::MR3_SEL: begin // RULE23
                    next_st.cal_mode = addr_in[ddr3_msc_pkg::MR3_CAL_EN_BIT]; // RULE1
                    // Pattern select only counts when readout is on.
                    if (addr_in[ddr3_msc_pkg::MR3_CAL_EN_BIT]) begin
                        next_st.cal_sel = addr_in[ddr3_msc_pkg::MR3_SEL_LSB +: 2]; // RULE24
                    end
                end
                ddr3_msc_pkg::MR1_SEL: begin
                    next_st.dll_off = addr_in[ddr3_msc_pkg::MR1_DLL_OFF_BIT]; // RULE9
                    next_st.al_sel = addr_in[ddr3_msc_pkg::MR1_AL_LSB +: 2];
                    next_st.rtt_nom_en = addr_in[ddr3_msc_pkg::MR1_RTT_A2]
                                         | addr_in[ddr3_msc_pkg::MR1_RTT_A6]
                                         | addr_in[ddr3_msc_pkg::MR1_RTT_A9];
                    // Turning the DLL off drops any lock.
                    if (addr_in[ddr3_msc_pkg::MR1_DLL_OFF_BIT]) begin
                        next_st.dll_locked = 1'b0;
                        next_st.dllk_cnt = 10'h000;
                    end
                end
                ddr3_msc_pkg::MR0_SEL: begin
                    // A DLL reset with the DLL on starts the lock timer.
                    if (addr_in[ddr3_msc_pkg::MR0_DLL_RST_BIT] && !st.dll_off) begin
                        next_st.dll_locked = 1'b0;
                        next_st.dllk_cnt = ddr3_msc_pkg::TDLLK_CK;
                    end
                end
                default: begin
                    next_st.cal_mode = st.cal_mode;
                end
            endcase
        end
        // Read latency pipeline; a read marks its strobe slot.
        next_st.rd_pipe  = st.rd_pipe >> 1;
        next_st.cal_pipe = st.cal_pipe >> 1;
        if (cmd_ok && rd_cmd) begin
            next_st.rd_pipe = next_st.rd_pipe | (16'h0001 << 5'(lat - 5'h01)); // RULE10
            // Reads in pattern mode are served from the pattern register.
            if (st.cal_mode) begin
                next_st.cal_pipe = next_st.cal_pipe | (16'h0001 << 5'(lat - 5'h01)); // RULE3
            end
        end
        next_st.dqs_start = st.rd_pipe[0];
        next_st.rd_cal    = st.cal_pipe[0];
        // DLL-off mode has no termination support, so it is forced off there.
        // Termination follows ODT only while nominal termination is on.
        next_st.term_on = st.rtt_nom_en && odt_in && !st.dll_off
                          && (st.pstate == ddr3_msc_pkg::PS_ACTIVE); // RULE21
        // Power state tracking on CKE.
        case (st.pstate)
            ddr3_msc_pkg::PS_ACTIVE: begin
                // CKE falling picks self refresh or power-down.
                if (st.prev_cke && !cke_in) begin
                    if (ref_cmd) begin
                        next_st.pstate = ddr3_msc_pkg::PS_SREF;
                    end else begin
                        next_st.pstate = ddr3_msc_pkg::PS_PDOWN;
                    end
                    next_st.sre_cnt = 4'h0;
                end
            end
            ddr3_msc_pkg::PS_PDOWN, ddr3_msc_pkg::PS_SREF: begin
                // After tCKSRE the clock no longer matters.
                if (st.sre_cnt != ddr3_msc_pkg::TCKSRE_CK) begin
                    next_st.sre_cnt = 4'(st.sre_cnt + 4'h1);
                end else begin
                    next_st.clk_free = 1'b1; // RULE17
                end
                // CKE high ends the low power state.
                if (cke_in) begin
                    next_st.pstate = ddr3_msc_pkg::PS_ACTIVE;
                    next_st.clk_free = 1'b0;
                end
            end
            default: begin
                next_st.pstate = ddr3_msc_pkg::PS_ACTIVE;
            end
        endcase
    end

    // ****************************************
    // State register.
    // ****************************************
    // Reset clears every mode, including the pattern mode.
    // Every field returns to zero, so the first edge after release sees CKE
    // as low and no command can be taken before the second edge.
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0; // RULE6
        end else begin
            st <= next_st;
        end
    end

    // Outputs come straight from the state flops.
    assign cal_mode_out   = st.cal_mode;
    assign cal_sel_out    = st.cal_sel;
    assign dll_off_out    = st.dll_off;
    assign dll_locked_out = st.dll_locked;
    assign dqs_start_out  = st.dqs_start;
    assign rd_cal_out     = st.rd_cal;
    assign term_on_out    = st.term_on;
    assign clk_free_out   = st.clk_free;
    assign pstate_out     = st.pstate;

    // ****************************************
    // Assertions and covers.
    // ****************************************
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);

    // An MR3 write with A2 set turns the pattern mode on.
    a_cal_mode_on: assert property ( // RULE1
        (cmd_ok && mrs_cmd && ba_in == 3'h3 && addr_in[2]) |=> st.cal_mode)
        else $error("pattern mode not enabled");
    // A pattern read gives its strobe and source flag seven edges later.
    a_cal_read_src: assert property ( // RULE3
        (cmd_ok && rd_cmd && st.cal_mode && !st.dll_off && st.al_sel == 2'h0)
        |-> ##7 (st.dqs_start && st.rd_cal))
        else $error("pattern read not served");
    // Release of reset leaves the pattern mode off.
    a_reset_clear: assert property ( // RULE6
        $rose(rstn_in) |-> !st.cal_mode)
        else $error("pattern mode survives reset");
    // A NOP leaves every mode unchanged.
    a_nop_stable: assert property ( // RULE7
        (cmd_ok && nop_cmd) |=> $stable({st.cal_mode, st.dll_off, st.al_sel}))
        else $error("NOP changed a mode");
    // Deselect starts nothing new.
    a_deselect_ign: assert property ( // RULE8
        (cmd_in.cs_n && st.rd_pipe == 16'h0000 && st.dllk_cnt == 10'h000)
        |=> ($stable(st.cal_mode) && st.rd_pipe == 16'h0000))
        else $error("deselect started a command");
    // An MR1 write loads the DLL-off bit from A0.
    a_dll_off_set: assert property ( // RULE9
        (cmd_ok && mrs_cmd && ba_in == 3'h1) |=> st.dll_off == $past(addr_in[0]))
        else $error("DLL-off bit not loaded");
    // DLL-off reads strobe one edge sooner than latency six.
    a_dll_off_lat: assert property ( // RULE11
        (cmd_ok && rd_cmd && st.dll_off && st.al_sel == 2'h0) |-> ##6 st.dqs_start)
        else $error("DLL-off strobe timing wrong");
    // Pattern select holds when the MR3 write turns the mode off.
    a_sel_ignored: assert property ( // RULE24
        (cmd_ok && mrs_cmd && ba_in == 3'h3 && !addr_in[2]) |=> $stable(st.cal_sel))
        else $error("pattern select not ignored");
    // A write with BA2 high is not an MR3 write.
    a_mr3_decode: assert property ( // RULE23
        (cmd_ok && mrs_cmd && ba_in == 3'h7) |=> $stable(st.cal_mode))
        else $error("bad MR3 decode");
    // The clock is free only in a low power state.
    a_clk_free: assert property ( // RULE17
        st.clk_free |-> st.pstate != ddr3_msc_pkg::PS_ACTIVE)
        else $error("clock free while active");
    // Termination stays off while nominal termination is disabled.
    a_term_off: assert property ( // RULE21
        !st.rtt_nom_en |=> !st.term_on)
        else $error("termination on while disabled");
    // An MR3 write with A2 set loads the pattern select from A1 and A0.
    a_sel_load: assert property ( // RULE1
        (cmd_ok && mrs_cmd && ba_in == ddr3_msc_pkg::MR3_SEL && addr_in[2])
        |=> st.cal_sel == $past(addr_in[1:0]))
        else $error("pattern select not loaded");
    // An ordinary read in DLL-on mode never raises the pattern flag.
    a_array_read: assert property ( // RULE3
        (cmd_ok && rd_cmd && !st.cal_mode && !st.dll_off && st.al_sel == 2'h0)
        |-> ##7 (st.dqs_start && !st.rd_cal))
        else $error("array read flagged as pattern");
    // A DLL reset while the DLL is off leaves it unlocked.
    a_dll_rst_off: assert property ( // RULE9
        (cmd_ok && mrs_cmd && ba_in == ddr3_msc_pkg::MR0_SEL && addr_in[8] && st.dll_off)
        |=> !st.dll_locked)
        else $error("DLL reset acted while off");
    // No lock is ever reported while DLL-off mode is set.
    a_off_no_lock: assert property ( // RULE9
        st.dll_off |-> !st.dll_locked)
        else $error("lock reported in DLL-off mode");
    // With AL of CL-2 and the DLL on, the strobe slot follows AL plus CL.
    a_al_read: assert property ( // RULE11
        (cmd_ok && rd_cmd && !st.dll_off && st.al_sel == 2'h2) |-> ##11 st.dqs_start)
        else $error("additive latency strobe timing wrong");
    // Self refresh entry is taken on a refresh with CKE falling.
    a_sref_entry: assert property ( // RULE17
        (st.pstate == ddr3_msc_pkg::PS_ACTIVE && st.prev_cke && !cke_in && ref_cmd)
        |=> st.pstate == ddr3_msc_pkg::PS_SREF)
        else $error("self refresh not entered");
    // Once the clock is free, self refresh keeps every mode untouched.
    a_sref_hold: assert property ( // RULE17
        (st.pstate == ddr3_msc_pkg::PS_SREF && st.clk_free && !cke_in)
        |=> $stable({st.cal_mode, st.cal_sel, st.dll_off, st.al_sel}))
        else $error("mode changed in self refresh");

    c_cal_read: cover property (st.rd_cal);
    c_dll_off_read: cover property (st.dll_off && st.dqs_start);
    c_sref_free: cover property (st.pstate == ddr3_msc_pkg::PS_SREF && st.clk_free);
    c_dll_lock: cover property ($rose(st.dll_locked));
    c_pdown_free: cover property (st.pstate == ddr3_msc_pkg::PS_PDOWN && st.clk_free);
endmodule

// ### ddr3_msc_pkg.sv
// Constants and types shared by the DDR3 mode switch control block.
package ddr3_msc_pkg;
    // ****************************************
    // Mode register selection on the bank address.
    // ****************************************
    localparam logic [2:0] MR0_SEL = 3'h0; // Mode register 0.
    localparam logic [2:0] MR1_SEL = 3'h1; // Mode register 1.
    localparam logic [2:0] MR3_SEL = 3'h3; // Mode register 3.
    // ****************************************
    // Address bit positions inside mode register writes.
    // ****************************************
    localparam int MR1_DLL_OFF_BIT = 0; // Disables the DLL.
    localparam int MR1_AL_LSB      = 3; // Additive latency field.
    localparam int MR1_RTT_A2      = 2; // Nominal termination bits.
    localparam int MR1_RTT_A6      = 6;
    localparam int MR1_RTT_A9      = 9;
    localparam int MR0_DLL_RST_BIT = 8; // Starts a DLL reset.
    localparam int MR3_CAL_EN_BIT  = 2; // Turns on the pattern readout.
    localparam int MR3_SEL_LSB     = 0; // Pattern select field.
    // ****************************************
    // Latencies and timing counts.
    // ****************************************
    localparam logic [4:0] LAT_CL   = 5'h06; // Read latency supported.
    localparam logic [4:0] LAT_CWL  = 5'h06; // Write latency supported.
    localparam int         CLK_NS   = 10;    // Clock period in ns.
    localparam int         TCKSRE_NS = 10;   // Clock hold after entry.
    localparam logic [3:0] TCKSRE_CK = 4'((TCKSRE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [9:0] TDLLK_CK = 10'h200; // DLL lock time in cycles.
    // ****************************************
    // Types.
    // ****************************************
    // Command strobes, all active low.
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
    } cmd_s;
    // Power state of the device.
    typedef enum logic [1:0] {
        PS_ACTIVE = 2'b00,
        PS_PDOWN  = 2'b01,
        PS_SREF   = 2'b10
    } pstate_e;
    // Whole state of the control block.
    typedef struct packed {
        pstate_e     pstate;
        logic        prev_cke;
        logic        cal_mode;
        logic [1:0]  cal_sel;
        logic        dll_off;
        logic [1:0]  al_sel;
        logic        rtt_nom_en;
        logic [3:0]  sre_cnt;
        logic        clk_free;
        logic [9:0]  dllk_cnt;
        logic        dll_locked;
        logic [15:0] rd_pipe;
        logic [15:0] cal_pipe;
        logic        dqs_start;
        logic        rd_cal;
        logic        term_on;
    } st_s;
endpackage

// ### ddr3_ctrl_model.sv
// Behavioural memory controller that drives the command side of the block.
`timescale 1ns/1ps
module ddr3_ctrl_model #(
    parameter int TMOD_CK = 12 // Mode register settle time in cycles, plain default.
) (
    input  wire logic          clk_in,
    output logic               cke_out,
    output ddr3_msc_pkg::cmd_s cmd_out,
    output logic [2:0]         ba_out,
    output logic [15:0]        addr_out,
    output logic               odt_out
);
    // Idle command: chip selected, all strobes high.
    localparam ddr3_msc_pkg::cmd_s NOP = 4'h7;
    // ****************************************
    // Start-up state.
    // ****************************************
    // The controller starts idle, banks precharged, clock enabled, termination request low.
    initial begin
        cke_out  = 1'b1;
        cmd_out  = NOP;
        ba_out   = 3'h0;
        addr_out = 16'h0000;
        odt_out  = 1'b0;
    end
    // ****************************************
    // Command tasks.
    // ****************************************
    // Drives one command for one edge, then idles with the address lines turned over.
    task automatic send(input ddr3_msc_pkg::cmd_s c, input logic [2:0] b, input logic [15:0] a);
        @(posedge clk_in);
        cmd_out  <= c;
        ba_out   <= b;
        addr_out <= a;
        @(posedge clk_in);
        cmd_out  <= NOP;
        ba_out   <= ~b;
        addr_out <= ~a;
    endtask
    // Mode register write; in pattern mode the bench only sends reads or MR3 between.
    task automatic mrs(input logic [2:0] b, input logic [15:0] a);
        send(4'h0, b, a);
    endtask
    // Plain read command.
    task automatic read();
        send(4'h5, 3'h0, 16'h0000);
    endtask
    // Waits with idle commands while a timing interval runs out.
    task automatic idle(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // Changes the termination request on the next edge.
    task automatic set_odt(input logic v);
        @(posedge clk_in);
        odt_out <= v;
    endtask
    // Lowers CKE with a refresh command for self refresh, or alone for power-down.
    task automatic enter_low(input logic sref, input logic odt);
        @(posedge clk_in);
        cke_out <= 1'b0;
        odt_out <= odt;
        cmd_out <= sref ? ddr3_msc_pkg::cmd_s'(4'h1) : NOP;
        @(posedge clk_in);
        cmd_out <= NOP;
    endtask
    // Raises CKE and keeps it high through the settle time after the exit.
    task automatic leave_low();
        @(posedge clk_in);
        cke_out <= 1'b1;
        repeat (TMOD_CK) @(posedge clk_in);
    endtask
endmodule

// ### test_ddr3_mode_switch_control.sv
// Self-checking bench for the DDR3 mode switch control block.
`timescale 1ns/1ps
module test_ddr3_mode_switch_control;
    logic               mclk_in = 1'b0;  // Device clock.
    logic               rstn_in = 1'b0;  // Active low reset.
    int                 half_ns = 5;     // Half period; changed only in self refresh.
    int                 n_fail  = 0;     // Mismatch count.
    int                 n_tests = 0;     // Comparison count.
    int                 n;               // Measured latency.
    logic               cke, odt, cal_mode, dll_off, dll_locked, dqs_start, rd_cal;
    logic               term_on, clk_free;
    logic [1:0]         cal_sel, pstate;
    logic [2:0]         ba;
    logic [15:0]        addr;
    ddr3_msc_pkg::cmd_s cmd;
    // Clock generator; its rate is altered during self refresh only.
    always begin
        #(half_ns);
        mclk_in = ~mclk_in;
    end
    ddr3_ctrl_model ctrl (.clk_in(mclk_in), .cke_out(cke), .cmd_out(cmd), .ba_out(ba),
        .addr_out(addr), .odt_out(odt));
    ddr3_mode_switch_control i_ddr3_mode_switch_control (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .cke_in(cke), .cmd_in(cmd), .ba_in(ba), .addr_in(addr), .odt_in(odt),
        .cal_mode_out(cal_mode), .cal_sel_out(cal_sel), .dll_off_out(dll_off),
        .dll_locked_out(dll_locked), .dqs_start_out(dqs_start), .rd_cal_out(rd_cal),
        .term_on_out(term_on), .clk_free_out(clk_free), .pstate_out(pstate));
    // ****************************************
    // Checking tasks.
    // ****************************************
    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("tests %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Compares a design output with case inequality so unknowns fail.
    task automatic chk_val(input logic [1:0] got, input logic [1:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask
    // Compares a cycle count measured by the bench.
    task automatic chk_cnt(input int got, input int exp, input string msg);
        n_tests++;
        if (got != exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %0d", $time, msg, got);
        end
    endtask
    // Moves just past the next edge, when its updates have landed.
    task automatic settle();
        @(posedge mclk_in);
        #1;
    endtask
    // Issues a read and counts edges until the strobe slot marker appears.
    task automatic read_lat(input int exp_lat, input logic exp_cal);
        ctrl.read();
        n = 0;
        do begin
            settle();
            n++;
        end while (dqs_start !== 1'b1 && n < 40);
        chk_cnt(n, exp_lat, "read strobe latency");
        chk_val(rd_cal, exp_cal, "pattern read flag");
        if (n >= 40) tally_and_finish();
        // Both markers stand for one cycle only.
        settle();
        chk_val({dqs_start, rd_cal}, 2'h0, "read pulse ends");
    endtask
    // Counts edges from a DLL reset until lock is reported.
    task automatic lock_lat();
        n = 0;
        while (dll_locked !== 1'b1 && n < 600) begin
            settle();
            n++;
        end
        chk_cnt(n, int'(ddr3_msc_pkg::TDLLK_CK), "DLL lock time");
        if (n >= 600) tally_and_finish();
    endtask
    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        repeat (20) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (2) settle();
        chk_val(pstate, 2'h0, "power state after reset");
        chk_val(dll_locked, 1'b0, "lock after reset");
        read_lat(6, 1'b0);
        // A deselected cycle carrying an MR3 enable must start nothing.
        ctrl.send(4'h8, ddr3_msc_pkg::MR3_SEL, 16'h0004);
        settle();
        chk_val(cal_mode, 1'b0, "deselect ignored");
        ctrl.mrs(3'h7, 16'h0004);
        settle();
        chk_val(cal_mode, 1'b0, "BA2 high is not MR3");
        ctrl.mrs(ddr3_msc_pkg::MR3_SEL, 16'h0006);
        settle();
        chk_val(cal_mode, 1'b1, "pattern mode on");
        chk_val(cal_sel, 2'h2, "pattern select");
        read_lat(6, 1'b1);
        read_lat(6, 1'b1);
        ctrl.mrs(ddr3_msc_pkg::MR3_SEL, 16'h0001);
        settle();
        chk_val(cal_mode, 1'b0, "pattern mode off");
        chk_val(cal_sel, 2'h2, "select kept when off");
        read_lat(6, 1'b0);
        // A reset in mid-run must clear pattern mode.
        ctrl.mrs(ddr3_msc_pkg::MR3_SEL, 16'h0004);
        @(posedge mclk_in);
        rstn_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (2) settle();
        chk_val(cal_mode, 1'b0, "reset clears pattern mode");
        ctrl.mrs(ddr3_msc_pkg::MR1_SEL, 16'h0001);
        settle();
        chk_val(dll_off, 1'b1, "DLL off");
        read_lat(5, 1'b0);
        ctrl.mrs(ddr3_msc_pkg::MR1_SEL, 16'h0009);
        read_lat(10, 1'b0);
        ctrl.mrs(ddr3_msc_pkg::MR0_SEL, 16'h0100);
        ctrl.idle(520);
        chk_val(dll_locked, 1'b0, "DLL reset ignored while off");
        // Self refresh with a slower clock while the device ignores it.
        ctrl.enter_low(1'b1, 1'b0);
        #1;
        chk_val(pstate, 2'h2, "self refresh entry");
        repeat (2) settle();
        chk_val(clk_free, 1'b1, "clock free after hold");
        half_ns = 9;
        ctrl.idle(10);
        half_ns = 5;
        ctrl.idle(4);
        chk_val(pstate, 2'h2, "stays in self refresh");
        ctrl.leave_low();
        chk_val(pstate, 2'h0, "self refresh exit");
        chk_val(clk_free, 1'b0, "clock held after exit");
        ctrl.mrs(ddr3_msc_pkg::MR1_SEL, 16'h0000);
        settle();
        chk_val(dll_off, 1'b0, "DLL back on");
        ctrl.idle(4);
        ctrl.mrs(ddr3_msc_pkg::MR0_SEL, 16'h0100);
        lock_lat();
        read_lat(6, 1'b0);
        // AL of CL-2 with the DLL on: strobe slot at AL plus CL.
        ctrl.mrs(ddr3_msc_pkg::MR1_SEL, 16'h0010);
        read_lat(10, 1'b0);
        // Termination follows the request only with nominal termination set.
        ctrl.mrs(ddr3_msc_pkg::MR1_SEL, 16'h0004);
        ctrl.set_odt(1'b1);
        repeat (2) settle();
        chk_val(term_on, 1'b1, "termination on");
        ctrl.enter_low(1'b0, 1'b0);
        #1;
        chk_val(pstate, 2'h1, "power-down entry");
        repeat (2) settle();
        chk_val(clk_free, 1'b1, "clock free in power-down");
        chk_val(term_on, 1'b0, "termination off in power-down");
        ctrl.leave_low();
        ctrl.mrs(ddr3_msc_pkg::MR1_SEL, 16'h0000);
        ctrl.enter_low(1'b0, 1'b1);
        repeat (3) settle();
        chk_val(term_on, 1'b0, "termination stays off");
        ctrl.leave_low();
        chk_val(term_on, 1'b0, "no nominal termination");
        tally_and_finish();
    end
endmodule
